/* verilog/sos_defs.vh */
// constants for the safety output supervisor
`ifndef SOS_DEFS_VH
`define SOS_DEFS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SOS_CLK_MHZ      100
`define SOS_PULSE_US     640
`define SOS_HOLD_MS      1000
`define SOS_PERIOD_MS    100
`define SOS_CUT_MS       10
`define SOS_SETTLE_US    10

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SOS_REG_DUAL     8'h00
`define SOS_REG_TPEN     8'h04
`define SOS_REG_UNUSED   8'h08
`define SOS_REG_EVENT    8'h0C
`define SOS_REG_MASK     8'h10
`define SOS_REG_STATE    8'h14
`define SOS_REG_ERRCLR   8'h18
`define SOS_REG_DATA     8'h1C

// ----------------------------------------
// state register field positions
// ----------------------------------------
`define SOS_ST_DONE      16
`define SOS_ST_PASS      17
`define SOS_ST_HOLD      18
`define SOS_ST_SUPBAD    19
`define SOS_ST_CUT       20
`define SOS_ST_OUT_LSB   8

// ----------------------------------------
// reset values
// ----------------------------------------
`define SOS_RST_CFG      32'h0000_0000
`define SOS_RST_MASK     32'h0000_0000

`endif

/* verilog/sos_sync.v */
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
`default_nettype none

module sos_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {W{1'b0}};
      q_o  <= {W{1'b0}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

`default_nettype wire

/* verilog/sos_pulse_gen.v */
// off test pulse timing, rotating over the terminals
`timescale 1ns/100ps
`default_nettype none

module sos_pulse_gen #(
  parameter N          = 4,
  parameter SW         = 2,
  parameter PERIOD_CYC = 10000000,
  parameter PULSE_CYC  = 64000
) (
  input  wire          clk_i,
  input  wire          rst_i,
  output reg           pulse_o,
  output reg           chk_o,
  output reg  [SW-1:0] sel_o
);

  reg [31:0] cnt;

  // pulse sits in the last PULSE_CYC cycles of each period
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt     <= 32'h0000_0000;
      pulse_o <= 1'b0;
      chk_o   <= 1'b0;
      sel_o   <= {SW{1'b0}};
    end else begin
      chk_o <= 1'b0;
      if (cnt == PERIOD_CYC - 1) begin
        cnt     <= 32'h0000_0000;
        pulse_o <= 1'b0;
        chk_o   <= 1'b1;
      end else begin
        cnt <= cnt + 32'h0000_0001;
        if (cnt == PERIOD_CYC - PULSE_CYC - 1)
          pulse_o <= 1'b1;
      end
      // one terminal per period so neighbours are never pulsed together
      if (chk_o) begin
        if (sel_o == N - 1)
          sel_o <= {SW{1'b0}};
        else
          sel_o <= sel_o + {{(SW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

/* verilog/sos_top.v */
// safety output supervisor: mapping, diagnosis, supply monitor, shut-off test
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "sos_defs.vh"

module sos_top #(
  parameter N          = 4,
  parameter SW         = 2,
  parameter PULSE_CYC  = `SOS_PULSE_US * `SOS_CLK_MHZ,
  parameter HOLD_CYC   = `SOS_HOLD_MS * 1000 * `SOS_CLK_MHZ,
  parameter PERIOD_CYC = `SOS_PERIOD_MS * 1000 * `SOS_CLK_MHZ,
  parameter CUT_CYC    = `SOS_CUT_MS * 1000 * `SOS_CLK_MHZ,
  parameter SETTLE_CYC = `SOS_SETTLE_US * `SOS_CLK_MHZ
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         wb_cyc_i,
  input  wire         wb_stb_i,
  input  wire         wb_we_i,
  input  wire [7:0]   wb_adr_i,
  input  wire [3:0]   wb_sel_i,
  input  wire [31:0]  wb_dat_i,
  output reg  [31:0]  wb_dat_o,
  output reg          wb_ack_o,
  input  wire [N-1:0] safe_data_i,
  input  wire         refresh_i,
  input  wire [N-1:0] term_fb_i,
  input  wire [N-1:0] oc_i,
  input  wire         pwr_ok_i,
  input  wire         pwr_on_i,
  output reg  [N-1:0] term_o,
  output reg          io_cut_o,
  output reg          irq_o
);

  localparam EW = 2 * N + 2;
  localparam ST_IDLE = 2'b00;
  localparam ST_CUT  = 2'b01;
  localparam ST_DONE = 2'b10;
  localparam [31:0] RST_CFG  = `SOS_RST_CFG;
  localparam [31:0] RST_MASK = `SOS_RST_MASK;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1)
        merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  function [31:0] zext;
    input [EW-1:0] v;
    begin
      zext = {{(32-EW){1'b0}}, v};
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [2*N+1:0] pins_s;
  wire [N-1:0]   fb_s;
  wire [N-1:0]   oc_s;
  wire           pwr_ok_s;
  wire           pwr_on_s;

  sos_sync #(.W(2*N+2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({pwr_on_i, pwr_ok_i, oc_i, term_fb_i}),
    .q_o   (pins_s)
  );

  assign fb_s     = pins_s[N-1:0];
  assign oc_s     = pins_s[2*N-1:N];
  assign pwr_ok_s = pins_s[2*N];
  assign pwr_on_s = pins_s[2*N+1];

  // ----------------------------------------
  // test pulse timing
  // ----------------------------------------
  wire          tp_pulse;
  wire          tp_chk;
  wire [SW-1:0] tp_sel;

  sos_pulse_gen #(
    .N          (N),
    .SW         (SW),
    .PERIOD_CYC (PERIOD_CYC),
    .PULSE_CYC  (PULSE_CYC)
  ) u_pulse (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pulse_o (tp_pulse),
    .chk_o   (tp_chk),
    .sel_o   (tp_sel)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [N/2-1:0] cfg_dual;
  reg  [N-1:0]   cfg_tp;
  reg  [N-1:0]   cfg_unused;
  reg  [EW-1:0]  evt;
  reg  [EW-1:0]  evt_mask;
  reg  [N-1:0]   err_lat;
  reg  [31:0]    hold_cnt;
  reg  [31:0]    settle_cnt;
  reg  [31:0]    st_cnt;
  reg  [1:0]     st_state;
  reg            st_pass;
  reg            sup_bad_d;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_req & wb_we_i;

  // ----------------------------------------
  // supply monitor and self-test
  // ----------------------------------------
  wire mon_en  = ~(&cfg_unused) & (st_state == ST_DONE);
  wire sup_bad = mon_en & ~pwr_ok_s;
  wire st_fail = (st_state == ST_DONE) & ~st_pass;
  wire kill    = sup_bad | ~st_pass | (st_state != ST_DONE);

  // start covers both arrival orders of refresh and supply
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_state <= ST_IDLE;
      st_cnt   <= 32'h0000_0000;
      st_pass  <= 1'b0;
      io_cut_o <= 1'b0;
    end else begin
      case (st_state)
        ST_IDLE: begin
          if (refresh_i & pwr_on_s) begin
            st_state <= ST_CUT;
            io_cut_o <= 1'b1;
            st_cnt   <= 32'h0000_0000;
          end
        end
        ST_CUT: begin
          if (st_cnt == CUT_CYC - 1) begin
            st_state <= ST_DONE;
            st_pass  <= ~pwr_on_s;
            io_cut_o <= 1'b0;
          end else begin
            st_cnt <= st_cnt + 32'h0000_0001;
          end
        end
        ST_DONE: begin
          st_state <= ST_DONE;
        end
        default: begin
          st_state <= ST_IDLE;
          io_cut_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // output mapping and diagnosis
  // ----------------------------------------
  reg [N-1:0] want;
  reg [N-1:0] err_pair;
  reg [N-1:0] pulsing;
  reg [N-1:0] wire_err;
  reg [N-1:0] next_term;
  integer i;

  always @* begin
    want     = {N{1'b0}};
    err_pair = {N{1'b0}};
    pulsing  = {N{1'b0}};
    wire_err = {N{1'b0}};
    for (i = 0; i < N; i = i + 1) begin
      if (cfg_dual[i/2]) begin
        want[i]     = safe_data_i[i - (i % 2)];
        err_pair[i] = err_lat[i - (i % 2)] | err_lat[i - (i % 2) + 1];
      end else begin
        want[i]     = safe_data_i[i];
        err_pair[i] = err_lat[i];
      end
      want[i] = want[i] & ~cfg_unused[i];
      // gated on want: gating on term_o would switch the pulse off again next cycle
      pulsing[i] = cfg_tp[i] & tp_pulse & (tp_sel == i) & want[i];
      if (settle_cnt == SETTLE_CYC && !cfg_unused[i]) begin
        // off but high: supply contact or short to an on neighbour
        if (!term_o[i] && !pulsing[i] && fb_s[i] && !(cfg_tp[i] && tp_sel == i && tp_chk))
          wire_err[i] = 1'b1;
        // on but low: ground fault
        if (term_o[i] && fb_s[i] == 1'b0)
          wire_err[i] = 1'b1;
      end
      // still high at the end of its off pulse: stuck high or on-on short
      if (cfg_tp[i] && tp_chk && tp_sel == i && want[i] && fb_s[i])
        wire_err[i] = 1'b1;
    end
    next_term = want & ~err_pair & ~oc_s & ~pulsing & {N{~kill}};
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      term_o     <= {N{1'b0}};
      settle_cnt <= 32'h0000_0000;
    end else begin
      term_o <= next_term;
      // diagnosis waits for the wiring to settle after each edge
      if (next_term != term_o)
        settle_cnt <= 32'h0000_0000;
      else if (settle_cnt != SETTLE_CYC)
        settle_cnt <= settle_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // error latch and hold timer
  // ----------------------------------------
  wire [N-1:0] err_set   = wire_err | oc_s;
  wire         hold_busy = (hold_cnt != 32'h0000_0000);
  wire         clr_hit   = wb_wr & (wb_adr_i == `SOS_REG_ERRCLR) & wb_sel_i[0];
  wire [N-1:0] err_clr   = (clr_hit & ~hold_busy) ? wb_dat_i[N-1:0] : {N{1'b0}};

  always @(posedge clk_i) begin
    if (rst_i) begin
      err_lat  <= {N{1'b0}};
      hold_cnt <= 32'h0000_0000;
    end else begin
      err_lat <= (err_lat & ~err_clr) | err_set;
      // clear refused until a full second has passed since the last error set
      if (|err_set)
        hold_cnt <= HOLD_CYC;
      else if (hold_busy)
        hold_cnt <= hold_cnt - 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  wire [EW-1:0] evt_set = {st_fail & (st_cnt == CUT_CYC - 1),
                           sup_bad & ~sup_bad_d,
                           oc_s,
                           wire_err};
  wire [31:0]   w1c_wr  = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  wire [EW-1:0] evt_w1c = (wb_wr && wb_adr_i == `SOS_REG_EVENT) ?
                          w1c_wr[EW-1:0] : {EW{1'b0}};

  always @(posedge clk_i) begin
    if (rst_i) begin
      evt       <= {EW{1'b0}};
      sup_bad_d <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      sup_bad_d <= sup_bad;
      evt       <= (evt & ~evt_w1c) | evt_set;
      irq_o     <= |(evt & evt_mask);
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  wire [31:0] state_word = {11'h000, io_cut_o, sup_bad, hold_busy, st_pass,
                            st_state == ST_DONE, {(8-N){1'b0}}, term_o,
                            {(8-N){1'b0}}, err_lat};
  wire [31:0] dual_wr    = merge({{(32-N/2){1'b0}}, cfg_dual}, wb_dat_i, wb_sel_i);
  wire [31:0] tp_wr      = merge({{(32-N){1'b0}}, cfg_tp}, wb_dat_i, wb_sel_i);
  wire [31:0] unus_wr    = merge({{(32-N){1'b0}}, cfg_unused}, wb_dat_i, wb_sel_i);
  wire [31:0] mask_wr    = merge(zext(evt_mask), wb_dat_i, wb_sel_i);

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
      cfg_dual   <= RST_CFG[N/2-1:0];
      cfg_tp     <= RST_CFG[N-1:0];
      cfg_unused <= RST_CFG[N-1:0];
      evt_mask   <= RST_MASK[EW-1:0];
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_wr) begin
        case (wb_adr_i)
          `SOS_REG_DUAL:   cfg_dual   <= dual_wr[N/2-1:0];
          `SOS_REG_TPEN:   cfg_tp     <= tp_wr[N-1:0];
          `SOS_REG_UNUSED: cfg_unused <= unus_wr[N-1:0];
          `SOS_REG_MASK:   evt_mask   <= mask_wr[EW-1:0];
          default:         evt_mask   <= evt_mask;
        endcase
      end else if (wb_req) begin
        case (wb_adr_i)
          `SOS_REG_DUAL:   wb_dat_o <= {{(32-N/2){1'b0}}, cfg_dual};
          `SOS_REG_TPEN:   wb_dat_o <= {{(32-N){1'b0}}, cfg_tp};
          `SOS_REG_UNUSED: wb_dat_o <= {{(32-N){1'b0}}, cfg_unused};
          `SOS_REG_EVENT:  wb_dat_o <= zext(evt);
          `SOS_REG_MASK:   wb_dat_o <= zext(evt_mask);
          `SOS_REG_STATE:  wb_dat_o <= state_word;
          `SOS_REG_DATA:   wb_dat_o <= {{(32-N){1'b0}}, safe_data_i};
          default:         wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* verification/sos_load_model.sv */
// load and supply model seen from the output terminals
`timescale 1ns/100ps
`default_nettype none

module sos_load_model #(
  parameter N = 4
) (
  input  wire logic [N-1:0] term_i,
  input  wire logic         cut_i,
  input  wire logic [N-1:0] stuck_i,
  input  wire logic [N-1:0] gnd_i,
  input  wire logic         sup_i,
  input  wire logic         bad_cut_i,
  output logic      [N-1:0] fb_o,
  output logic              on_o
);
  // ground fault wins over a short to the positive line
  assign fb_o = (term_i | stuck_i) & ~gnd_i;
  // a broken shut-off path leaves the supply up through the cut
  assign on_o = sup_i & ~(cut_i & ~bad_cut_i);
endmodule

`default_nettype wire

/* verification/sos_top_monitor.sv */
// port checker for the safety output supervisor
`timescale 1ns/100ps
`default_nettype none

module sos_top_monitor #(
  parameter N       = 4,
  parameter CUT_CYC = 5
) (
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_ack_o,
  input wire logic [N-1:0] safe_data_i,
  input wire logic         refresh_i,
  input wire logic [N-1:0] oc_i,
  input wire logic         pwr_ok_i,
  input wire logic         pwr_on_i,
  input wire logic [N-1:0] term_o,
  input wire logic         io_cut_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        cut_seen;
  logic [31:0] cut_n;
  // --------------------------------
  // cut length and once-only record
  // --------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      cut_seen <= 1'h0;
      cut_n    <= 32'h0000_0000;
    end else begin
      if (!io_cut_o && cut_n != 32'h0000_0000) begin
        cut_seen <= 1'h1;
      end
      cut_n <= io_cut_o ? cut_n + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  a_single_map: assert property (
    $rose(term_o[0]) |-> $past(safe_data_i[0])) else $error("term 0 on without data");
  a_pair_drive: assert property (
    $rose(term_o[1]) |-> $past(safe_data_i[1] | safe_data_i[0])) else $error("term 1 on");
  a_oc_off: assert property (
    (term_o & $past(oc_i, 3)) == 0) else $error("terminal on under overcurrent");
  a_supply_off: assert property (
    !$past(pwr_ok_i, 3) |-> term_o == 0) else $error("terminal on with bad supply");
  a_cut_start: assert property (
    $rose(io_cut_o) |-> $past(refresh_i) && $past(pwr_on_i, 3)) else $error("cut uncaused");
  a_cut_len: assert property (
    $fell(io_cut_o) |-> cut_n == CUT_CYC) else $error("cut length wrong");
  a_cut_once: assert property (
    cut_seen |-> !io_cut_o) else $error("second shut-off test");
  a_term_gated: assert property (
    term_o != 0 |-> cut_seen) else $error("terminal on before self-test");
  a_ack_taken: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
endmodule

bind sos_top sos_top_monitor #(.N(N), .CUT_CYC(CUT_CYC)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .safe_data_i(safe_data_i), .refresh_i(refresh_i), .oc_i(oc_i),
  .pwr_ok_i(pwr_ok_i), .pwr_on_i(pwr_on_i), .term_o(term_o), .io_cut_o(io_cut_o));

`default_nettype wire

/* verification/tb_sos_top.sv */
// self-checking bench for the safety output supervisor
`timescale 1ns/100ps
`default_nettype none
`include "sos_defs.vh"

module tb_sos_top;
  logic        clk_i, rst_i, cyc, stb, we, ack, refresh, pok, pon, cut, irq, sup, badc;
  logic [7:0]  adr;
  logic [31:0] dw, dr, q;
  logic [3:0]  safe, fb, oc, term, stuck, gnd, sel, lanes;
  int          err_count, tests_run, run, mx;

  sos_top #(.PULSE_CYC(4), .HOLD_CYC(30), .PERIOD_CYC(20), .CUT_CYC(5), .SETTLE_CYC(2)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .safe_data_i(safe), .refresh_i(refresh), .term_fb_i(fb), .oc_i(oc), .pwr_ok_i(pok),
    .pwr_on_i(pon), .term_o(term), .io_cut_o(cut), .irq_o(irq));
  sos_load_model u_load (.term_i(term), .cut_i(cut), .stuck_i(stuck), .gnd_i(gnd),
    .sup_i(sup), .bad_cut_i(badc), .fb_o(fb), .on_o(pon));

  task close_out;
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // --------------------------------
  // classic wishbone cycle
  // --------------------------------
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we  <= w;
    adr <= a;
    dw  <= d;
    sel <= lanes;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'h1 && i < 50);
    q = dr;
    cyc <= 1'h0;
    stb <= 1'h0;
    we  <= 1'h0;
    if (i >= 50) begin
      err_count++;
      $display("[ERR] %0t bus timeout", $time);
      close_out;
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    wb(1'h0, a, 32'h0000_0000);
    chk(q & m, v);
  endtask
  // bounded wait on a register field, then one compare
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int i;
    for (i = 0; i < 300; i++) begin
      wb(1'h0, a, 32'h0000_0000);
      if ((q & m) === v) break;
    end
    chk(q & m, v);
    if (i >= 300) close_out;
  endtask
  task clr;
    poll(`SOS_REG_STATE, 32'h0004_0000, 32'h0000_0000);
    wb(1'h1, `SOS_REG_ERRCLR, 32'h0000_000F);
    wb(1'h1, `SOS_REG_EVENT, 32'h0000_03FF);
  endtask

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    {rst_i, sup, pok} = 3'h7;
    {cyc, stb, we, refresh, badc} = 5'h00;
    {adr, dw, safe, oc, stuck, gnd} = 56'h0;
    sel = 4'hF;
    lanes = 4'hF;
    err_count = 0;
    tests_run = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (8) @(posedge clk_i);
    rc(`SOS_REG_STATE, 32'h0001_0000, 32'h0000_0000);
    refresh <= 1'h1;
    poll(`SOS_REG_STATE, 32'h0003_0000, 32'h0003_0000);
    safe <= 4'hA;
    poll(`SOS_REG_STATE, 32'h0000_0F00, 32'h0000_0A00);
    chk(32'(term), 32'h0000_000A);
    rc(`SOS_REG_DATA, 32'hFFFF_FFFF, 32'h0000_000A);
    rc(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    oc <= 4'h8;
    poll(`SOS_REG_STATE, 32'h0000_0F00, 32'h0000_0200);
    rc(`SOS_REG_EVENT, 32'h0000_0FFF, 32'h0000_0080);
    oc <= 4'h0;
    repeat (6) @(posedge clk_i);
    rc(`SOS_REG_STATE, 32'h0000_0F00, 32'h0000_0200);
    clr;
    poll(`SOS_REG_STATE, 32'h0000_0F00, 32'h0000_0A00);
    pok <= 1'h0;
    poll(`SOS_REG_EVENT, 32'h0000_0100, 32'h0000_0100);
    chk(32'(term), 32'h0000_0000);
    pok <= 1'h1;
    clr;
    // interrupt, mask and the error hold
    stuck <= 4'h4;
    poll(`SOS_REG_EVENT, 32'h0000_0004, 32'h0000_0004);
    chk(32'(irq), 32'h0000_0000);
    wb(1'h1, `SOS_REG_MASK, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0000_0001);
    stuck <= 4'h0;
    wb(1'h1, `SOS_REG_ERRCLR, 32'h0000_000F);
    rc(`SOS_REG_STATE, 32'h0000_0004, 32'h0000_0004);
    wb(1'h1, `SOS_REG_EVENT, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0000_0000);
    clr;
    rc(`SOS_REG_STATE, 32'h0000_000F, 32'h0000_0000);
    wb(1'h1, `SOS_REG_DUAL, 32'h0000_0001);
    safe <= 4'h1;
    poll(`SOS_REG_STATE, 32'h0000_0F00, 32'h0000_0300);
    gnd <= 4'h2;
    poll(`SOS_REG_STATE, 32'h0000_0F00, 32'h0000_0000);
    gnd <= 4'h0;
    repeat (6) @(posedge clk_i);
    rc(`SOS_REG_STATE, 32'h0000_0F00, 32'h0000_0000);
    clr;
    poll(`SOS_REG_STATE, 32'h0000_0F00, 32'h0000_0300);
    wb(1'h1, `SOS_REG_DUAL, 32'h0000_0000);
    wb(1'h1, `SOS_REG_TPEN, 32'h0000_0001);
    run = 0;
    mx = 0;
    repeat (200) begin
      @(posedge clk_i);
      run = term[0] ? 0 : run + 1;
      if (run > mx) mx = run;
    end
    chk(mx, 32'h0000_0004);
    rc(`SOS_REG_EVENT, 32'h0000_0FFF, 32'h0000_0000);
    stuck <= 4'h1;
    poll(`SOS_REG_EVENT, 32'h0000_0001, 32'h0000_0001);
    stuck <= 4'h0;
    clr;
    wb(1'h1, `SOS_REG_UNUSED, 32'h0000_000F);
    pok <= 1'h0;
    repeat (8) @(posedge clk_i);
    rc(`SOS_REG_EVENT, 32'h0000_0100, 32'h0000_0000);
    pok <= 1'h1;
    // second power-on: supply late, shut-off path broken
    rst_i <= 1'h1;
    sup <= 1'h0;
    badc <= 1'h1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (10) @(posedge clk_i);
    rc(`SOS_REG_STATE, 32'h0001_0000, 32'h0000_0000);
    sup <= 1'h1;
    poll(`SOS_REG_STATE, 32'h0003_0000, 32'h0001_0000);
    rc(`SOS_REG_EVENT, 32'h0000_0200, 32'h0000_0200);
    // only byte lane 1 may land: mask bit 9 set, low lane ignored
    lanes = 4'h2;
    wb(1'h1, `SOS_REG_MASK, 32'h0000_02FF);
    lanes = 4'hF;
    rc(`SOS_REG_MASK, 32'hFFFF_FFFF, 32'h0000_0200);
    chk(32'(irq), 32'h0000_0001);
    safe <= 4'h5;
    repeat (8) @(posedge clk_i);
    chk(32'(term), 32'h0000_0000);
    close_out;
  end
endmodule

`default_nettype wire
